// *** sac_pkg.sv ***
package sac_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int RES_BITS = 16;
  localparam int BYTE_BITS = 8;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int CONV_MAX_NS = 4700;
  // Longest time rounds down
  localparam int CONV_CYCLES = (CONV_MAX_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int SAR_STEP_CYCLES = 2;
  localparam int REF_WAKE_MS = 12;
  // Least time rounds down
  localparam int REF_WAKE_CYCLES = REF_WAKE_MS * (CLK_HZ / 1000);
  localparam int DO_DELAY_CYCLES = 1;
  localparam int SYNC_STAGES = 3;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [RES_BITS-1:0] RESULT_RST = 16'h0000;
  localparam logic [7:0] BUS_OE_N_RST = 8'hFF;
  // ****************************************
  // Sequencer states (Gray from idle through read)
  // ****************************************
  typedef enum logic [2:0] {
    SAC_IDLE = 3'b000,
    SAC_ACQ = 3'b001,
    SAC_CONV = 3'b011,
    SAC_DONE = 3'b010,
    SAC_READ = 3'b110
  } sac_state_t;
endpackage

// *** sac_sync.sv ***
`timescale 1ns/1ps
module sac_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_async,
  output logic o_level
);
  import sac_pkg::*;
  logic [sac_pkg::SYNC_STAGES-1:0] stage_reg;
  // ****************************************
  // Three stages, change taken when last two agree
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      stage_reg <= {SYNC_STAGES{RST_VAL}};
    end else begin
      stage_reg <= {stage_reg[SYNC_STAGES-2:0], i_async};
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_level <= RST_VAL;
    end else if (stage_reg[SYNC_STAGES-1] == stage_reg[SYNC_STAGES-2]) begin
      o_level <= stage_reg[SYNC_STAGES-1];
    end
  end
endmodule

// *** sac_conv_ctrl.sv ***
`timescale 1ns/1ps
// Contract
// [R01] First strobe fall with read/convert low powers up and starts acquisition.
// [R02] Strobe fall with read/convert high is ignored as a convert start.
// [R03] Host waits 12 ms after wake from shutdown before converting.
// [R04] Standby keeps reference and buffer powered between conversions.
// [R05] Shutdown turns reference and buffer off after conversion completes.
// [R06] Read/convert at second fall picks standby (low) or shutdown (high).
// [R07] From standby, strobe fall with read/convert low begins acquisition.
// [R08] From shutdown, strobe fall with read/convert low wakes reference, acquires.
// [R09] End-of-conversion flag goes low when a conversion completes.
// [R10] All result outputs high impedance during acquisition and conversion.
// [R11] Third strobe fall with read/convert high drives result after delay.
// [R12] Strobe high releases bus; then wait for next fall to start.
// [R13] Upper byte select low shows low byte, high shows high byte.
// [R14] Result coded as straight binary.
// [R15] Host switches mux channels right after acquisition ends.
// [R16] Second strobe fall ends acquisition, holds, and starts conversion.
// [R17] Conversion completes within 4.7 us of second strobe fall.
// [R18] Host waits for end-of-conversion low before third strobe fall.
module sac_conv_ctrl #(
  // Reference settle count, a parameter so that it can be shortened
  parameter int REF_WAKE_N = sac_pkg::REF_WAKE_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_cs_n,
  input wire logic i_rd_conv,
  input wire logic i_upper_byte_select,
  input wire logic i_cmp,
  output logic [sac_pkg::BYTE_BITS-1:0] o_data,
  output logic [sac_pkg::BYTE_BITS-1:0] o_data_oe_n,
  output logic o_eoc_n,
  output logic o_ref_on,
  output logic o_track,
  output logic o_ref_ready,
  output logic [sac_pkg::RES_BITS-1:0] o_dac_code
);
  import sac_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic cs_n_s;
  logic rc_s;
  logic hb_s;
  logic cs_n_d_reg;
  logic cs_fall;
  logic cs_rise;

  sac_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_async(i_cs_n),
    .o_level(cs_n_s)
  );
  sac_sync #(.RST_VAL(1'b0)) u_sync_rc (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_async(i_rd_conv),
    .o_level(rc_s)
  );
  sac_sync #(.RST_VAL(1'b0)) u_sync_hb (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_async(i_upper_byte_select),
    .o_level(hb_s)
  );
  // Comparator settles off the registered DAC code within one step;
  // a synchroniser here would lag the bit trials by four cycles
  logic cmp_s;
  assign cmp_s = i_cmp;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cs_n_d_reg <= 1'b1;
    end else begin
      cs_n_d_reg <= cs_n_s;
    end
  end
  assign cs_fall = cs_n_d_reg & ~cs_n_s;
  assign cs_rise = ~cs_n_d_reg & cs_n_s;

  // ****************************************
  // Sequencer
  // ****************************************
  sac_state_t state_reg;
  logic shutdown_sel_reg;
  logic [15:0] conv_cnt_reg;
  logic [4:0] bit_idx_reg;
  logic [RES_BITS-1:0] sar_reg;
  logic [RES_BITS-1:0] result_reg;
  logic [1:0] do_cnt_reg;
  logic sar_last;
  logic step_tick;

  assign step_tick = (conv_cnt_reg[0] == 1'b1);
  assign sar_last = (bit_idx_reg == 5'd0);

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_reg <= SAC_IDLE;
    end else begin
      case (state_reg)
        SAC_IDLE: begin
          if (cs_fall && !rc_s) begin
            state_reg <= SAC_ACQ; // [R01] [R07] [R08]
          end
        end
        SAC_ACQ: begin
          if (cs_fall) begin
            state_reg <= SAC_CONV; // [R16]
          end
        end
        SAC_CONV: begin
          // Bit trials finish well inside the ceiling
          if ((step_tick && sar_last) || conv_cnt_reg >= 16'(CONV_CYCLES - 1)) begin
            state_reg <= SAC_DONE; // [R17]
          end
        end
        SAC_DONE: begin
          if (cs_fall && rc_s) begin
            state_reg <= SAC_READ; // [R11]
          end else if (cs_fall) begin
            state_reg <= SAC_ACQ; // [R07] [R08]
          end
        end
        SAC_READ: begin
          if (cs_rise) begin
            state_reg <= SAC_IDLE; // [R12]
          end
        end
        default: begin
          state_reg <= SAC_IDLE;
        end
      endcase
    end
  end
  // Falls with read/convert high in idle drop here: [R02]

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      shutdown_sel_reg <= 1'b0;
    end else if (state_reg == SAC_ACQ && cs_fall) begin
      shutdown_sel_reg <= rc_s; // [R06]
    end
  end

  // ****************************************
  // SAR engine
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      conv_cnt_reg <= 16'h0000;
      bit_idx_reg <= 5'(RES_BITS - 1);
      sar_reg <= RESULT_RST;
    end else if (state_reg == SAC_ACQ && cs_fall) begin
      conv_cnt_reg <= 16'h0000;
      bit_idx_reg <= 5'(RES_BITS - 1);
      sar_reg <= {1'b1, {(RES_BITS-1){1'b0}}};
    end else if (state_reg == SAC_CONV) begin
      conv_cnt_reg <= conv_cnt_reg + 16'h0001;
      if (step_tick) begin
        // Keep trial bit when input is above the DAC level
        sar_reg[bit_idx_reg[3:0]] <= cmp_s;
        if (!sar_last) begin
          sar_reg[bit_idx_reg[3:0] - 4'h1] <= 1'b1;
          bit_idx_reg <= bit_idx_reg - 5'd1;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      result_reg <= RESULT_RST;
    end else if (state_reg == SAC_CONV && step_tick && sar_last) begin
      result_reg <= {sar_reg[RES_BITS-1:1], cmp_s}; // [R14]
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_eoc_n <= 1'b1;
    end else if (state_reg == SAC_CONV && (step_tick && sar_last
                 || conv_cnt_reg >= 16'(CONV_CYCLES - 1))) begin
      o_eoc_n <= 1'b0; // [R09]
    end else if (cs_fall) begin
      o_eoc_n <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_ref_on <= 1'b0;
    end else if ((state_reg == SAC_IDLE || state_reg == SAC_DONE) && cs_fall && !rc_s) begin
      o_ref_on <= 1'b1; // [R08]
    end else if (state_reg == SAC_CONV && o_eoc_n == 1'b0 && shutdown_sel_reg) begin
      o_ref_on <= 1'b0; // [R05]
    end else if (state_reg == SAC_DONE && shutdown_sel_reg) begin
      o_ref_on <= 1'b0; // [R05]
    end
    // Standby leaves o_ref_on set between conversions: [R04]
  end

  // Reference settle indicator; host owns the wait itself
  logic [17:0] wake_cnt_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !o_ref_on) begin
      wake_cnt_reg <= 18'h0_0000;
      o_ref_ready <= 1'b0;
    end else if (wake_cnt_reg >= 18'(REF_WAKE_N - 1)) begin
      o_ref_ready <= 1'b1; // [R03]
    end else begin
      wake_cnt_reg <= wake_cnt_reg + 18'h0_0001;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_track <= 1'b0;
    end else begin
      o_track <= (state_reg == SAC_ACQ) && !cs_fall; // [R16]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_dac_code <= RESULT_RST;
    end else begin
      o_dac_code <= sar_reg;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      do_cnt_reg <= 2'b00;
    end else if (state_reg != SAC_READ) begin
      do_cnt_reg <= 2'b00;
    end else if (do_cnt_reg < 2'(DO_DELAY_CYCLES)) begin
      do_cnt_reg <= do_cnt_reg + 2'b01;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_data_oe_n <= BUS_OE_N_RST;
      o_data <= 8'h00;
    end else if (state_reg == SAC_READ && !cs_rise && do_cnt_reg >= 2'(DO_DELAY_CYCLES)) begin
      o_data_oe_n <= 8'h00; // [R11]
      o_data <= hb_s ? result_reg[15:8] : result_reg[7:0]; // [R13]
    end else begin
      o_data_oe_n <= BUS_OE_N_RST; // [R10] [R12]
      o_data <= 8'h00;
    end
  end
endmodule

// *** sac_analog_model.sv ***
`timescale 1ns/1ps
module sac_analog_model (
  input wire logic [15:0] i_vin,
  input wire logic i_track,
  input wire logic [15:0] i_dac_code,
  output logic o_cmp
);
  logic [15:0] held;
  // Hold capacitor follows the input only while tracking
  always_latch begin
    if (i_track) begin
      held <= i_vin;
    end
  end
  // Half-LSB offset so either comparator reading gives the same code
  assign o_cmp = {held, 1'b1} > {i_dac_code, 1'b0};
endmodule

// *** sac_conv_ctrl_asserts.sv ***
`timescale 1ns/1ps
module sac_conv_ctrl_asserts (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_cs_n,
  input wire logic i_rd_conv,
  input wire logic [sac_pkg::BYTE_BITS-1:0] o_data_oe_n,
  input wire logic o_eoc_n,
  input wire logic o_ref_on,
  input wire logic o_track
);
  import sac_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  sequence s_conv_end;
    ##[1:47] $fell(o_eoc_n);
  endsequence
  sequence s_bus_free;
    ##[1:8] (o_data_oe_n == 8'hFF);
  endsequence
  a_bus_off_acq: assert property (o_track |-> o_data_oe_n == 8'hFF)
    else $error("bus driven in track");
  a_bus_whole: assert property (o_data_oe_n == 8'hFF || o_data_oe_n == 8'h00)
    else $error("bus enables split");
  a_conv_time: assert property ($fell(o_track) |-> s_conv_end)
    else $error("conversion too slow");
  a_start_rc_low: assert property ($rose(o_track) |-> !$past(i_rd_conv, 4))
    else $error("acquire with rc high");
  a_hold_on_fall: assert property ($fell(o_track) |-> !$past(i_cs_n, 2))
    else $error("hold without strobe");
  a_ref_in_acq: assert property (o_track |-> o_ref_on)
    else $error("reference off in track");
  a_ref_in_conv: assert property ($fell(o_track) |-> o_ref_on [*8])
    else $error("reference off in conversion");
  a_read_rc_high: assert property ($fell(o_data_oe_n[0]) |-> $past(i_rd_conv, 4))
    else $error("read with rc low");
  a_bus_release: assert property ($rose(i_cs_n) |-> s_bus_free)
    else $error("bus not released");
endmodule
bind sac_conv_ctrl sac_conv_ctrl_asserts i_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
  .i_cs_n(i_cs_n), .i_rd_conv(i_rd_conv), .o_data_oe_n(o_data_oe_n), .o_eoc_n(o_eoc_n),
  .o_ref_on(o_ref_on), .o_track(o_track));

// *** testbench.sv ***
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("wrong value %s exp %h got %h", nm, exp, got); \
  end \
end
module testbench;
  import sac_pkg::*;
  logic i_sys_clk = 0;
  logic i_srst = 1;
  logic i_cs_n = 1;
  logic i_rd_conv = 0;
  logic i_upper_byte_select = 0;
  logic cmp;
  logic [15:0] vin = 16'h0000;
  logic [7:0] data, oe_n;
  logic eoc_n, ref_on, track, ref_ready;
  logic [15:0] dac;
  int n_mismatch = 0;
  int total_checks = 0;
  initial forever #50 i_sys_clk = ~i_sys_clk;
  // Short settle count keeps the run brief
  sac_conv_ctrl #(.REF_WAKE_N(200)) i_sac_conv_ctrl (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .i_cs_n(i_cs_n),
    .i_rd_conv(i_rd_conv), .i_upper_byte_select(i_upper_byte_select), .i_cmp(cmp),
    .o_data(data), .o_data_oe_n(oe_n), .o_eoc_n(eoc_n), .o_ref_on(ref_on),
    .o_track(track), .o_ref_ready(ref_ready), .o_dac_code(dac));
  sac_analog_model i_sac_analog_model (.i_vin(vin), .i_track(track), .i_dac_code(dac),
    .o_cmp(cmp));
  // ********
  // Host side
  // ********
  task automatic step(int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic strobe(logic rc);
    i_rd_conv = rc;
    i_cs_n = 0;
    step(8);
    i_cs_n = 1;
    step(8);
  endtask
  task automatic wait_eoc;
    int n;
    n = 0;
    while (eoc_n !== 1'b0 && n < 60) begin
      step(1);
      n++;
    end
    `CHK("eoc_n", 1'b0, eoc_n)
  endtask
  task automatic conv(logic [15:0] v, logic mode);
    int n;
    vin = v;
    strobe(0);
    `CHK("track", 1'b1, track)
    `CHK("ref_on", 1'b1, ref_on)
    n = 0;
    while (ref_ready !== 1'b1 && n < 400) begin
      step(1);
      n++;
    end
    `CHK("ref_ready", 1'b1, ref_ready)
    strobe(mode);
    `CHK("track", 1'b0, track)
    `CHK("oe_n", 8'hFF, oe_n)
    // Next channel goes on right after the sample is held
    vin = ~v;
    wait_eoc();
    step(2);
    `CHK("ref_on", ~mode, ref_on)
    i_rd_conv = 1;
    i_cs_n = 0;
    step(8);
    `CHK("oe_n", 8'h00, oe_n)
    `CHK("low byte", v[7:0], data)
    i_upper_byte_select = 1;
    step(6);
    `CHK("high byte", v[15:8], data)
    i_upper_byte_select = 0;
    i_cs_n = 1;
    step(8);
    `CHK("oe_n", 8'hFF, oe_n)
  endtask
  // ********
  // Scenarios
  // ********
  task automatic scn_ignore;
    strobe(1);
    `CHK("track", 1'b0, track)
    `CHK("ref_on", 1'b0, ref_on)
  endtask
  task automatic scn_standby;
    conv(16'h0000, 1'b0);
    `CHK("ref_on", 1'b1, ref_on)
    conv(16'hA53C, 1'b0);
    `CHK("eoc_n", 1'b1, eoc_n)
  endtask
  task automatic scn_skip;
    strobe(0);
    strobe(0);
    wait_eoc();
    // Result left unread: the next acquisition starts from done
    conv(16'h1234, 1'b0);
  endtask
  task automatic scn_shutdown;
    conv(16'hFFFF, 1'b1);
    `CHK("ref_on", 1'b0, ref_on)
    `CHK("ref_ready", 1'b0, ref_ready)
    conv(16'h5AC3, 1'b0);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    step(20);
    i_srst = 0;
    step(1);
    scn_ignore();
    scn_standby();
    scn_skip();
    scn_shutdown();
    end_of_test();
  end
  initial begin
    repeat (3000) @(posedge i_sys_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule
